// ---- tbips_pkg.sv ----
/*
 * Shared definitions for the two-bit I/O port with shared serial pins:
 * register indices, byte addresses, reset values, bus response codes,
 * state encodings and the per-pin configuration carrier.
 * Assumes a 32-bit AXI4-Lite register bus with a 16-bit byte address.
 */
package tbips_pkg;

	// Port geometry
	localparam int PORT_BITS = 2;
	localparam int REG_WIDTH = 8;
	localparam int AXI_ADDR_W = 16;
	localparam int AXI_DATA_W = 32;

	// Register indices as printed; byte address is four times the index
	localparam logic [15:0] IDX_PIN_LEVEL_READBACK = 16'h0016;
	localparam logic [15:0] IDX_OUTPUT_LATCH = 16'h0009;
	localparam logic [15:0] IDX_DIRECTION_SELECT = 16'h0F23;
	localparam logic [15:0] IDX_PULLUP_ENABLE = 16'h0F30;
	localparam logic [15:0] IDX_FUNCTION_SELECT = 16'h0F3D;
	localparam logic [15:0] IDX_OUTPUT_TYPE_SELECT = 16'h0F4A;

	localparam logic [15:0] ADDR_PIN_LEVEL_READBACK = 16'h0058;
	localparam logic [15:0] ADDR_OUTPUT_LATCH = 16'h0024;
	localparam logic [15:0] ADDR_DIRECTION_SELECT = 16'h3C8C;
	localparam logic [15:0] ADDR_PULLUP_ENABLE = 16'h3CC0;
	localparam logic [15:0] ADDR_FUNCTION_SELECT = 16'h3CF4;
	localparam logic [15:0] ADDR_OUTPUT_TYPE_SELECT = 16'h3D28;

	// Reset value of every writable control field
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// Level the receive line idles at when no pin feeds it
	localparam logic RX_IDLE_LEVEL = 1'h1;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Write channel states, one-hot
	typedef enum logic [1:0] {
		WR_COLLECT = 2'h1,
		WR_RESPOND = 2'h2
	} tbips_wr_state_type;

	// Read channel states, one-hot
	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_RESPOND = 2'h2
	} tbips_rd_state_type;

	// Everything one pin cell needs from the register bank
	typedef struct packed {
		logic outputMode;
		logic serialFunction;
		logic openDrain;
		logic pullupRequest;
		logic latchValue;
	} tbips_pin_cfg_type;

	// What one pin cell hands back
	typedef struct packed {
		logic padOut;
		logic padOeN;
		logic pullupOn;
		logic readback;
	} tbips_pin_stat_type;

endpackage : tbips_pkg

// ---- tbips_pin_cell.sv ----
/*
 * One pin of the port: selects the output source, shapes push-pull or
 * open-drain drive, gates the pull-up and forms the readback bit.
 * Assumes the pad level arrives synchronous to the core clock.
 */
`timescale 1ns/1ps
module tbips_pin_cell import tbips_pkg::*; (
	input wire tbips_pin_cfg_type cfg,
	input wire logic uartTransmitLine,
	input wire logic padIn,
	output tbips_pin_stat_type stat
);

	logic driveValue;

	// Port latch or transmitter, whichever the function bit picks
	assign driveValue = cfg.serialFunction ? uartTransmitLine
		: cfg.latchValue;

	// Pin drive; open-drain only ever sinks, a high is released.
	// One process fills the whole status word, so it has one driver.
	always_comb begin
		stat.padOut = driveValue;
		if (!cfg.outputMode) begin
			stat.padOeN = 1'b1;
		end else if (cfg.openDrain) begin
			stat.padOeN = driveValue;
		end else begin
			stat.padOeN = 1'b0;
		end
		// Pull-up only where nothing drives high
		stat.pullupOn = cfg.pullupRequest
			& (~cfg.outputMode | cfg.openDrain);
		// Push-pull outputs read back zero, not their own drive
		stat.readback = (~cfg.outputMode | cfg.openDrain)
			& padIn;
	end

endmodule : tbips_pin_cell

// ---- tbips_port.sv ----
/*
 * Two-bit general-purpose I/O port whose pins double as the transmit
 * and receive lines of one serial channel, with its register bank on an
 * AXI4-Lite slave. Assumes synchronous pad inputs, an external pad that
 * resolves level from padOut and active-low padOeN, and a separate
 * serial pin selector that tells which pin is the receive pin.
 */
// The AXI4-Lite register port is this design's own decision.
// How it works
// - Output mode with latch zero drives the pin low.
// - Output latch one drives high; open-drain releases it instead.
// - Direction bit zero is input, one is output; bits 1 and 0 only.
// - Function bit zero takes the port latch, one the serial transmitter.
// - Output-type bit zero is push-pull, one is sink open-drain.
// - Pull-up connects only in input mode or open-drain.
// - Readback gives pin level, except zero for push-pull output.
// - Receive line takes the pin level while that pin is input.
// - Each pin's direction is set independently of the other.
`timescale 1ns/1ps
module tbips_port import tbips_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pads: port_pin_zero is bit 0, port_pin_one is bit 1
	input wire logic [PORT_BITS-1:0] padIn,
	output logic [PORT_BITS-1:0] padOut,
	output logic [PORT_BITS-1:0] padOeN,
	output logic [PORT_BITS-1:0] pullupOn,
	// Serial channel
	input wire logic uartTransmitLine,
	output logic uartReceiveLine,
	input wire logic receivePinSelect
);

	// Control registers, two live bits each
	logic [PORT_BITS-1:0] outputLatch_q;
	logic [PORT_BITS-1:0] directionSelect_q;
	logic [PORT_BITS-1:0] pullupEnable_q;
	logic [PORT_BITS-1:0] functionSelect_q;
	logic [PORT_BITS-1:0] outputTypeSelect_q;

	// Write channel
	tbips_wr_state_type wrState_q;
	logic awHeld_q;
	logic wHeld_q;
	logic [AXI_ADDR_W-1:0] wrAddr_q;
	logic [PORT_BITS-1:0] wrData_q;
	logic wrLaneZero_q;
	logic [1:0] bresp_q;
	logic awTake;
	logic wTake;
	logic wrFire;
	logic [AXI_ADDR_W-1:0] wrAddrNow;
	logic [PORT_BITS-1:0] wrDataNow;
	logic wrLaneNow;

	// Read channel
	tbips_rd_state_type rdState_q;
	logic [AXI_DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic arTake;

	// Pin cells
	tbips_pin_cfg_type [PORT_BITS-1:0] pinCfg;
	tbips_pin_stat_type [PORT_BITS-1:0] pinStat;
	logic [PORT_BITS-1:0] readbackBits;

	// Address decode shared by both channels; anything else is unmapped
	function automatic logic addrMapped(input logic [AXI_ADDR_W-1:0] a);
		case (a)
			ADDR_PIN_LEVEL_READBACK, ADDR_OUTPUT_LATCH,
			ADDR_DIRECTION_SELECT, ADDR_PULLUP_ENABLE,
			ADDR_FUNCTION_SELECT, ADDR_OUTPUT_TYPE_SELECT: begin
				addrMapped = 1'b1;
			end
			default: begin
				addrMapped = 1'b0;
			end
		endcase
	endfunction : addrMapped

	// ------------------------------------------------------------
	// Write channel: address and data may arrive in either order
	// ------------------------------------------------------------

	// Each half is taken once and held until the other half lands
	assign s_axi_awready = (wrState_q == WR_COLLECT) & ~awHeld_q;
	assign s_axi_wready = (wrState_q == WR_COLLECT) & ~wHeld_q;
	assign awTake = s_axi_awvalid & s_axi_awready;
	assign wTake = s_axi_wvalid & s_axi_wready;

	// Fire in the cycle the second half lands, so no cycle is wasted
	assign wrFire = (wrState_q == WR_COLLECT)
		& (awHeld_q | awTake) & (wHeld_q | wTake);
	assign wrAddrNow = awHeld_q ? wrAddr_q : s_axi_awaddr;
	assign wrDataNow = wHeld_q ? wrData_q : s_axi_wdata[PORT_BITS-1:0];
	assign wrLaneNow = wHeld_q ? wrLaneZero_q : s_axi_wstrb[0];

	// Capture of the two halves
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			wrAddr_q <= '0;
			wrData_q <= '0;
			wrLaneZero_q <= 1'b0;
		end else if (wrFire) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
		end else begin
			if (awTake) begin
				awHeld_q <= 1'b1;
				wrAddr_q <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld_q <= 1'b1;
				wrData_q <= s_axi_wdata[PORT_BITS-1:0];
				wrLaneZero_q <= s_axi_wstrb[0];
			end
		end
	end

	// Write state and response
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrState_q <= WR_COLLECT;
			bresp_q <= RESP_OKAY;
		end else begin
			case (wrState_q)
				WR_COLLECT: begin
					if (wrFire) begin
						wrState_q <= WR_RESPOND;
						bresp_q <= addrMapped(wrAddrNow)
							? RESP_OKAY : RESP_SLVERR;
					end
				end
				WR_RESPOND: begin
					if (s_axi_bready) begin
						wrState_q <= WR_COLLECT;
					end
				end
				default: begin
					wrState_q <= WR_COLLECT;
				end
			endcase
		end
	end

	assign s_axi_bvalid = (wrState_q == WR_RESPOND);
	assign s_axi_bresp = bresp_q;

	// ------------------------------------------------------------
	// Register bank; only byte lane 0 carries live bits
	// ------------------------------------------------------------

	// Each register written only when lane 0 is strobed
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			outputLatch_q <= CTRL_RESET;
			directionSelect_q <= CTRL_RESET;
			pullupEnable_q <= CTRL_RESET;
			functionSelect_q <= CTRL_RESET;
			outputTypeSelect_q <= CTRL_RESET;
		end else if (wrFire && wrLaneNow) begin
			case (wrAddrNow)
				ADDR_OUTPUT_LATCH: begin
					outputLatch_q <= wrDataNow;
				end
				ADDR_DIRECTION_SELECT: begin
					directionSelect_q <= wrDataNow;
				end
				ADDR_PULLUP_ENABLE: begin
					pullupEnable_q <= wrDataNow;
				end
				ADDR_FUNCTION_SELECT: begin
					functionSelect_q <= wrDataNow;
				end
				ADDR_OUTPUT_TYPE_SELECT: begin
					outputTypeSelect_q <= wrDataNow;
				end
				default: begin
					// Readback is read-only; unmapped writes drop
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------

	assign s_axi_arready = (rdState_q == RD_IDLE);
	assign arTake = s_axi_arvalid & s_axi_arready;

	// Pin level is sampled at the address edge, not when rready arrives
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdState_q <= RD_IDLE;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			case (rdState_q)
				RD_IDLE: begin
					if (arTake) begin
						rdState_q <= RD_RESPOND;
						rresp_q <= addrMapped(s_axi_araddr)
							? RESP_OKAY : RESP_SLVERR;
						rdata_q <= '0;
						case (s_axi_araddr)
							ADDR_PIN_LEVEL_READBACK: begin
								rdata_q[PORT_BITS-1:0] <= readbackBits;
							end
							ADDR_OUTPUT_LATCH: begin
								rdata_q[PORT_BITS-1:0] <= outputLatch_q;
							end
							ADDR_DIRECTION_SELECT: begin
								rdata_q[PORT_BITS-1:0] <= directionSelect_q;
							end
							ADDR_PULLUP_ENABLE: begin
								rdata_q[PORT_BITS-1:0] <= pullupEnable_q;
							end
							ADDR_FUNCTION_SELECT: begin
								rdata_q[PORT_BITS-1:0] <= functionSelect_q;
							end
							ADDR_OUTPUT_TYPE_SELECT: begin
								rdata_q[PORT_BITS-1:0] <= outputTypeSelect_q;
							end
							default: begin
								rdata_q <= '0;
							end
						endcase
					end
				end
				RD_RESPOND: begin
					if (s_axi_rready) begin
						rdState_q <= RD_IDLE;
					end
				end
				default: begin
					rdState_q <= RD_IDLE;
				end
			endcase
		end
	end

	assign s_axi_rvalid = (rdState_q == RD_RESPOND);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------

	// One cell per pin, each with its own direction and controls
	generate
		for (genvar i = 0; i < PORT_BITS; i++) begin : gPin
			assign pinCfg[i].outputMode = directionSelect_q[i];
			assign pinCfg[i].serialFunction = functionSelect_q[i];
			assign pinCfg[i].openDrain = outputTypeSelect_q[i];
			assign pinCfg[i].pullupRequest = pullupEnable_q[i];
			assign pinCfg[i].latchValue = outputLatch_q[i];

			tbips_pin_cell uPinCell (
				.cfg(pinCfg[i]),
				.uartTransmitLine(uartTransmitLine),
				.padIn(padIn[i]),
				.stat(pinStat[i])
			);

			assign padOut[i] = pinStat[i].padOut;
			assign padOeN[i] = pinStat[i].padOeN;
			assign pullupOn[i] = pinStat[i].pullupOn;
			assign readbackBits[i] = pinStat[i].readback;
		end
	endgenerate

	// Receive line follows the selected pin only while it is an input;
	// the pin choice itself belongs to the external serial selector
	always_comb begin
		if (!directionSelect_q[receivePinSelect]) begin
			uartReceiveLine = padIn[receivePinSelect];
		end else begin
			uartReceiveLine = RX_IDLE_LEVEL;
		end
	end

endmodule : tbips_port

// ---- tbips_port_sva.sv ----
/* Checker for the port's bus handshakes and pin relations.
   Sees only the port's pins; bound to every port instance. */
`timescale 1ns/1ps
module tbips_port_sva import tbips_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PORT_BITS-1:0] padOut,
	input wire logic [PORT_BITS-1:0] padOeN,
	input wire logic [PORT_BITS-1:0] pullupOn,
	input wire logic uartReceiveLine,
	input wire logic receivePinSelect
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_reset_idle:
	assert property ($rose(rst_n) |-> padOeN == 2'h3 && pullupOn == 2'h0)
		else $error("pins not idle after reset");
	a_pull_gated:
	assert property ((pullupOn & ~padOeN & padOut) == 2'h0)
		else $error("pull-up on a pin driven high");
	a_rx_idle_out:
	assert property (!padOeN[receivePinSelect] |-> uartReceiveLine)
		else $error("receive line not idle on an output pin");
	a_read_next:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_read_holds:
	assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_upper:
	assert property (s_axi_rvalid |-> s_axi_rdata[31:2] == 30'h0)
		else $error("unused read bits not zero");
	a_write_resp:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	a_bresp_holds:
	assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
endmodule : tbips_port_sva

bind tbips_port tbips_port_sva tbips_port_sva_i (.*);

// ---- tbips_pad_model.sv ----
/* Pad and outside-world model for both pins.
   Assumes the bench drives the outside levels at clock edges. */
`timescale 1ns/1ps
module tbips_pad_model import tbips_pkg::*; (
	input wire logic core_clk,
	input wire logic [PORT_BITS-1:0] padOut,
	input wire logic [PORT_BITS-1:0] padOeN,
	input wire logic [PORT_BITS-1:0] pullupOn,
	input wire logic [PORT_BITS-1:0] extEn,
	input wire logic [PORT_BITS-1:0] extDrive,
	output logic [PORT_BITS-1:0] padIn
);
	logic [PORT_BITS-1:0] floatQ = 2'h1;

	// A floating line wanders, so no stale level can pass for a real one
	always @(posedge core_clk) floatQ <= ~floatQ;

	// Chip drive wins, then the outside driver, then the pull-up
	always_comb begin
		for (int i = 0; i < PORT_BITS; i++) begin
			if (!padOeN[i]) padIn[i] = padOut[i];
			else if (extEn[i]) padIn[i] = extDrive[i];
			else if (pullupOn[i]) padIn[i] = 1'h1;
			else padIn[i] = floatQ[i];
		end
	end
endmodule : tbips_pad_model

// ---- tbips_port_tb.sv ----
/* Bench for the I/O port: bus tasks, pin checks and the verdict.
   Assumes the pad model resolves the pin levels. */
`timescale 1ns/1ps
module tbips_port_tb import tbips_pkg::*; ;
	logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic uartTransmitLine, uartReceiveLine, receivePinSelect;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, padIn, padOut, padOeN, pullupOn;
	logic [1:0] extEn, extDrive;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb;
	logic [15:0] ctl [5];
	int mismatches, compares;

	tbips_port tbips_port_i (.*);
	tbips_pad_model tbips_pad_model_i (.*);

	// Free-running core clock
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Compare one result and count it
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk

	// Enables, driven levels (released bits read 1) and pull-ups
	task automatic pin(input logic [1:0] oe, dv, pu);
		@(negedge core_clk);
		chk("padOeN", {30'h0, oe}, {30'h0, padOeN});
		chk("padDrive", {30'h0, dv}, {30'h0, padOut | padOeN});
		chk("pullupOn", {30'h0, pu}, {30'h0, pullupOn});
	endtask : pin

	// Outside drivers change only at a clock edge
	task automatic ext(input logic [1:0] en, dv);
		@(posedge core_clk);
		extEn <= en;
		extDrive <= dv;
	endtask : ext

	// Pick the receive pin and check the receive line
	task automatic rx(input logic s, e);
		@(posedge core_clk);
		receivePinSelect <= s;
		@(negedge core_clk);
		chk("uartReceiveLine", {31'h0, e}, {31'h0, uartReceiveLine});
	endtask : rx

	// One write; ready is looked at mid-cycle, where it has settled
	task automatic wr(input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge core_clk);
			ta = s_axi_awvalid && !s_axi_awready;
			tw = s_axi_wvalid && !s_axi_wready;
			@(posedge core_clk);
			s_axi_awvalid <= ta;
			s_axi_wvalid <= tw;
		end while (ta || tw);
		do @(negedge core_clk); while (!s_axi_bvalid);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge core_clk);
		s_axi_bready <= 1'h0;
	endtask : wr

	// One read, checked against the expected word and code
	task automatic rd(input logic [15:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ta;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge core_clk);
			ta = !s_axi_arready;
			@(posedge core_clk);
			s_axi_arvalid <= ta;
		end while (ta);
		do @(negedge core_clk); while (!s_axi_rvalid);
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge core_clk);
		s_axi_rready <= 1'h0;
	endtask : rd

	task end_of_test;
		if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// Reset, then the tests in order
	initial begin
		ctl = '{ADDR_OUTPUT_LATCH, ADDR_DIRECTION_SELECT, ADDR_PULLUP_ENABLE,
			ADDR_FUNCTION_SELECT, ADDR_OUTPUT_TYPE_SELECT};
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, receivePinSelect, extEn, extDrive} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wstrb = 4'hF;
		uartTransmitLine = 1'h1;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		foreach (ctl[i]) begin
			rd(ctl[i], 32'h0, RESP_OKAY);
			wr(ctl[i], 32'hFFFFFFFF, RESP_OKAY);
			rd(ctl[i], 32'h3, RESP_OKAY);
			wr(ctl[i], 32'h0, RESP_OKAY);
		end
		wr(16'h0010, 32'h3, RESP_SLVERR);
		rd(16'h0010, 32'h0, RESP_SLVERR);
		// Both pins inputs; a readback write must change nothing
		ext(2'h3, 2'h2);
		wr(ADDR_PIN_LEVEL_READBACK, 32'h3, RESP_OKAY);
		rd(ADDR_PIN_LEVEL_READBACK, 32'h2, RESP_OKAY);
		rx(1'h1, 1'h1);
		rx(1'h0, 1'h0);
		// Push-pull outputs ignore the pull-up request
		ext(2'h0, 2'h0);
		wr(ADDR_DIRECTION_SELECT, 32'h3, RESP_OKAY);
		wr(ADDR_OUTPUT_LATCH, 32'h1, RESP_OKAY);
		wr(ADDR_PULLUP_ENABLE, 32'h3, RESP_OKAY);
		pin(2'h0, 2'h1, 2'h3 & 2'h0);
		rd(ADDR_PIN_LEVEL_READBACK, 32'h0, RESP_OKAY);
		rx(1'h0, 1'h1);
		// Open drain: high releases to the pull-up, low sinks
		wr(ADDR_OUTPUT_TYPE_SELECT, 32'h3, RESP_OKAY);
		pin(2'h1, 2'h1, 2'h3);
		rd(ADDR_PIN_LEVEL_READBACK, 32'h1, RESP_OKAY);
		// Pin zero push-pull output, pin one input
		wr(ADDR_OUTPUT_TYPE_SELECT, 32'h0, RESP_OKAY);
		wr(ADDR_DIRECTION_SELECT, 32'h1, RESP_OKAY);
		ext(2'h2, 2'h2);
		pin(2'h2, 2'h3, 2'h2);
		rd(ADDR_PIN_LEVEL_READBACK, 32'h2, RESP_OKAY);
		rx(1'h1, 1'h1);
		// Transmitter takes over pin zero
		wr(ADDR_FUNCTION_SELECT, 32'h1, RESP_OKAY);
		uartTransmitLine <= 1'h0;
		pin(2'h2, 2'h2, 2'h2);
		// A mid-run reset clears every control
		@(posedge core_clk);
		rst_n <= 1'h0;
		@(posedge core_clk);
		rst_n <= 1'h1;
		pin(2'h3, 2'h3, 2'h0);
		rd(ADDR_FUNCTION_SELECT, 32'h0, RESP_OKAY);
		// Lane 0 not strobed: the write is answered but changes nothing
		s_axi_wstrb <= 4'hE;
		wr(ADDR_FUNCTION_SELECT, 32'h3, RESP_OKAY);
		rd(ADDR_FUNCTION_SELECT, 32'h0, RESP_OKAY);
		end_of_test;
	end

	// Give up long after the tests should have ended
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		end_of_test;
	end
endmodule : tbips_port_tb
